// ==== core/dtm_map.svh ====
// Constants of the data transfer message handler.
// Assumes inclusion by bare name from core files.
`ifndef DTM_MAP_SVH
`define DTM_MAP_SVH
`define DTM_CODE_REPLY 8'h21
`define DTM_CODE_REQUEST 8'h22
`define DTM_CODE_RESPONSE 8'h03
`define DTM_RC_INVALID_FIELD 8'hff
`define DTM_RSVD_BYTE 8'h00
`define DTM_LEN_REPLY 5'h10
`define DTM_LEN_REQUEST 5'h0e
`define DTM_LEN_RESPONSE 5'h04
`define DTM_ALERT_BAD_ROUTE 8'h01
`define DTM_ALERT_BAD_FIELD 8'h02
`define DTM_ALERT_UNEXPECTED 8'h03
`define DTM_ALERT_TOO_MANY 8'h04
`define DTM_ALIGN_MASK 3'h7
`define DTM_RX_LAST_IDX 4'hf
`endif

// ==== core/dtm_pkg.sv ====
// Types shared by the data transfer message handler.
// Assumes nothing beyond a SystemVerilog compiler.
package dtm_pkg;
    typedef struct packed {
        logic [15:0] tag;
        logic [15:0] ident;
        logic [31:0] count;
    } dtm_offer_type;
    typedef struct packed {
        logic [15:0] channel;
        logic [31:0] route;
        logic [31:0] count;
    } dtm_grant_type;
    typedef struct packed {
        logic [31:0] offset;
        logic [31:0] count;
        logic [15:0] channel;
    } dtm_req_type;
    typedef enum logic [0:0] {
        DTM_TX_IDLE = 1'b0,
        DTM_TX_SEND = 1'b1
    } dtm_tx_state_type;
endpackage

// ==== core/dtm_handler.sv ====
// Builds and checks data reply and data request messages; parses and checks received data replies.
// Assumes link framing, data frames and channel allocation sit outside, on the same clock.
`timescale 1ns/10ps
`include "dtm_map.svh"

module dtm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic full, empty;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_q[rd_q[AW-1:0]];

    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (in_valid_i && !full) begin
            wr_d = wr_q + 1'b1;
        end
        if (out_ready_i && !empty) begin
            rd_d = rd_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage needs no reset; empty flag guards stale words
    always_ff @(posedge sys_clk_i) begin
        if (in_valid_i && !full) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// Contract
// - Send data reply, code 21h, only answering a held offer; several allowed.
// - A sent reply stays outstanding until its final data frame arrives.
// - Reply is 16 bytes: code, reserved, tag, route, count, channel, identifier.
// - Reply tag copies the tag of the answered offer.
// - Received reply with wrong route raises bad-route alert, then keeps waiting.
// - Reply count multiple of eight unless last; violation gives invalid-field alert.
// - Granted data frames use reply channel and route as address.
// - Same-channel successive grants run in order; different channels may overlap. Code holds back only the last granted channel.
// - Reply carries the identifier of the answered offer.
// - Other bad reply field gets response FFh; route, unexpected, overflow alert.
// - Data request uses code 22h, several per process, outstanding till final frame.
// - Request is 14 bytes: code, reserved, tag, offset, count, channel.
// - Request tag copies the originating command tag.
// - Request offset is always a multiple of eight.
// - Request count multiple of eight except the request holding the final byte.
// - Request offset plus count never exceeds the process transfer length.
// - Channel is allocated before request; nonconforming request may abort process.
// - New request only when none outstanding or each has seen a frame.
// - Response code FFh means parsed but at least one field invalid.
module dtm_handler #(
    parameter int OUT_W = 4,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] cmd_tag_i,
    input wire logic [31:0] cmd_route_i,
    input wire logic [31:0] xfer_len_i,
    input wire logic [31:0] own_route_i,
    input wire logic offer_valid_i,
    input wire dtm_pkg::dtm_offer_type offer_i,
    input wire logic rep_go_i,
    input wire logic [15:0] rep_chan_i,
    input wire logic [31:0] rep_count_i,
    input wire logic rep_last_i,
    input wire logic rep_done_i,
    input wire logic req_go_i,
    input wire dtm_pkg::dtm_req_type req_i,
    input wire logic req_frame_first_i,
    input wire logic req_done_i,
    output logic cmd_err_o,
    output logic busy_o,
    output logic [OUT_W-1:0] rep_out_o,
    output logic [OUT_W-1:0] req_out_o,
    input wire logic rx_valid_i,
    input wire logic rx_sop_i,
    input wire logic [7:0] rx_data_i,
    input wire logic [15:0] exp_ident_i,
    input wire logic [31:0] data_left_i,
    output logic grant_valid_o,
    input wire logic grant_ready_i,
    output dtm_pkg::dtm_grant_type grant_o,
    input wire logic xmit_done_i,
    output logic alert_o,
    output logic [7:0] alert_code_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [7:0] tx_data_o
);
    dtm_pkg::dtm_tx_state_type st_q, st_d;
    logic [127:0] msg_q, msg_d;
    logic [4:0] left_q, left_d;
    dtm_pkg::dtm_offer_type offer_q, offer_d;
    logic offer_held_q, offer_held_d;
    logic [OUT_W-1:0] rep_out_q, rep_out_d, req_out_q, req_out_d, seen_q, seen_d;
    logic err_q, err_d, fifo_rdy, push;
    logic [127:0] rx_q, rx_d;
    logic [3:0] rx_idx_q, rx_idx_d;
    logic resp_pend_q, resp_pend_d;
    logic [15:0] resp_tag_q, resp_tag_d;
    dtm_pkg::dtm_grant_type pend_q, pend_d;
    logic pend_valid_q, pend_valid_d, act_q, act_d;
    logic [15:0] act_chan_q, act_chan_d;
    logic alert_q, alert_d;
    logic [7:0] acode_q, acode_d;
    logic [32:0] req_end;
    logic rep_ok, req_ok, rx_done, msg_start;
    logic [31:0] rx_route, rx_count;

    assign push = (st_q == dtm_pkg::DTM_TX_SEND);
    assign req_end = {1'b0, req_i.offset} + {1'b0, req_i.count};
    assign rep_ok = offer_held_q && ((rep_count_i[2:0] & `DTM_ALIGN_MASK) == 3'h0 || rep_last_i);
    assign req_ok = ((req_i.offset[2:0] & `DTM_ALIGN_MASK) == 3'h0)
        && ((req_i.count[2:0] & `DTM_ALIGN_MASK) == 3'h0 || req_end == {1'b0, xfer_len_i})
        && (req_end <= {1'b0, xfer_len_i})
        && (req_out_q == '0 || seen_q == req_out_q);
    assign msg_start = (st_q == dtm_pkg::DTM_TX_IDLE) && !resp_pend_q;
    assign rx_done = rx_valid_i && (rx_idx_q == `DTM_RX_LAST_IDX);
    assign rx_route = rx_d[95:64];
    assign rx_count = rx_d[63:32];

    // Message builder; a pending response goes ahead of new commands
    always_comb begin
        st_d = st_q;
        msg_d = msg_q;
        left_d = left_q;
        err_d = 1'b0;
        rep_out_d = rep_out_q;
        req_out_d = req_out_q;
        seen_d = seen_q;
        offer_d = offer_q;
        offer_held_d = offer_held_q;
        if (offer_valid_i) begin
            offer_d = offer_i;
            offer_held_d = 1'b1;
        end
        if (push && fifo_rdy) begin
            msg_d = {msg_q[119:0], 8'h00};
            left_d = left_q - 5'h01;
            if (left_q == 5'h01) begin
                st_d = dtm_pkg::DTM_TX_IDLE;
            end
        end
        if (rep_done_i && rep_out_q != '0) begin
            rep_out_d = rep_out_d - 1'b1;
        end
        if (req_frame_first_i && seen_q != req_out_q) begin
            seen_d = seen_q + 1'b1;
        end
        if (req_done_i && req_out_q != '0) begin
            req_out_d = req_out_q - 1'b1;
            seen_d = (seen_d != '0) ? seen_d - 1'b1 : seen_d;
        end
        if (st_q == dtm_pkg::DTM_TX_IDLE && resp_pend_q) begin
            msg_d = {`DTM_CODE_RESPONSE, `DTM_RC_INVALID_FIELD, resp_tag_q, 96'h0};
            left_d = `DTM_LEN_RESPONSE;
            st_d = dtm_pkg::DTM_TX_SEND;
        end else if (msg_start && rep_go_i) begin
            if (rep_ok) begin
                msg_d = {`DTM_CODE_REPLY, `DTM_RSVD_BYTE, offer_q.tag, own_route_i, rep_count_i,
                    rep_chan_i, offer_q.ident};
                left_d = `DTM_LEN_REPLY;
                st_d = dtm_pkg::DTM_TX_SEND;
                rep_out_d = rep_out_d + 1'b1;
            end else begin
                err_d = 1'b1;
            end
        end else if (msg_start && req_go_i) begin
            if (req_ok) begin
                msg_d = {`DTM_CODE_REQUEST, `DTM_RSVD_BYTE, cmd_tag_i, req_i.offset, req_i.count,
                    req_i.channel, 16'h0};
                left_d = `DTM_LEN_REQUEST;
                st_d = dtm_pkg::DTM_TX_SEND;
                req_out_d = req_out_d + 1'b1;
            end else begin
                err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= dtm_pkg::DTM_TX_IDLE;
            msg_q <= '0;
            left_q <= '0;
            err_q <= 1'b0;
            rep_out_q <= '0;
            req_out_q <= '0;
            seen_q <= '0;
            offer_q <= '0;
            offer_held_q <= 1'b0;
        end else begin
            st_q <= st_d;
            msg_q <= msg_d;
            left_q <= left_d;
            err_q <= err_d;
            rep_out_q <= rep_out_d;
            req_out_q <= req_out_d;
            seen_q <= seen_d;
            offer_q <= offer_d;
            offer_held_q <= offer_held_d;
        end
    end

    // Received reply checker and grant scheduler
    always_comb begin
        rx_d = rx_q;
        rx_idx_d = rx_idx_q;
        resp_pend_d = resp_pend_q;
        resp_tag_d = resp_tag_q;
        pend_d = pend_q;
        pend_valid_d = pend_valid_q;
        act_d = act_q;
        act_chan_d = act_chan_q;
        alert_d = 1'b0;
        acode_d = acode_q;
        if (st_q == dtm_pkg::DTM_TX_IDLE && resp_pend_q) begin
            resp_pend_d = 1'b0;
        end
        if (xmit_done_i) begin
            act_d = 1'b0;
        end
        if (grant_valid_o && grant_ready_i) begin
            pend_valid_d = 1'b0;
            act_d = 1'b1;
            act_chan_d = pend_q.channel;
        end
        if (rx_valid_i) begin
            rx_d = {rx_q[119:0], rx_data_i};
            rx_idx_d = rx_idx_q + 4'h1;
            if (rx_sop_i) begin
                rx_d = {120'h0, rx_data_i};
                rx_idx_d = 4'h1;
            end
        end
        if (rx_done && !rx_sop_i) begin
            rx_idx_d = 4'h0;
            if (rx_d[127:120] != `DTM_CODE_REPLY) begin
                alert_d = 1'b1;
                acode_d = `DTM_ALERT_UNEXPECTED;
            end else if (rx_route != cmd_route_i) begin
                alert_d = 1'b1;
                acode_d = `DTM_ALERT_BAD_ROUTE;
            end else if ((rx_count[2:0] & `DTM_ALIGN_MASK) != 3'h0 && rx_count < data_left_i) begin
                alert_d = 1'b1;
                acode_d = `DTM_ALERT_BAD_FIELD;
            end else if (rx_d[15:0] != exp_ident_i) begin
                resp_pend_d = 1'b1;
                resp_tag_d = rx_d[111:96];
            end else if (pend_valid_d) begin
                alert_d = 1'b1;
                acode_d = `DTM_ALERT_TOO_MANY;
            end else begin
                pend_d = '{channel: rx_d[31:16], route: rx_route, count: rx_count};
                pend_valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_q <= '0;
            rx_idx_q <= '0;
            resp_pend_q <= 1'b0;
            resp_tag_q <= '0;
            pend_q <= '0;
            pend_valid_q <= 1'b0;
            act_q <= 1'b0;
            act_chan_q <= '0;
            alert_q <= 1'b0;
            acode_q <= '0;
        end else begin
            rx_q <= rx_d;
            rx_idx_q <= rx_idx_d;
            resp_pend_q <= resp_pend_d;
            resp_tag_q <= resp_tag_d;
            pend_q <= pend_d;
            pend_valid_q <= pend_valid_d;
            act_q <= act_d;
            act_chan_q <= act_chan_d;
            alert_q <= alert_d;
            acode_q <= acode_d;
        end
    end

    // channel of the last grant waits until its transfer is done
    assign grant_valid_o = pend_valid_q && !(act_q && act_chan_q == pend_q.channel);
    assign grant_o = pend_q;
    assign alert_o = alert_q;
    assign alert_code_o = acode_q;
    assign cmd_err_o = err_q;
    assign busy_o = (st_q == dtm_pkg::DTM_TX_SEND) || resp_pend_q;
    assign rep_out_o = rep_out_q;
    assign req_out_o = req_out_q;

    // Outgoing bytes queue here so the link can stall the builder
    dtm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(push),
        .in_ready_o(fifo_rdy),
        .in_data_i(msg_q[127:120]),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o)
    );
endmodule

// ==== dv/dtm_handler_assertions.sv ====
// Port checker for the data transfer message handler.
// Assumes it is bound onto dtm_handler with the same counter width.
`timescale 1ns/10ps
module dtm_chk #(
    parameter int OUT_W = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [31:0] cmd_route_i,
    input wire logic [31:0] xfer_len_i,
    input wire logic offer_valid_i,
    input wire logic rep_go_i,
    input wire logic [31:0] rep_count_i,
    input wire logic rep_last_i,
    input wire logic rep_done_i,
    input wire logic req_go_i,
    input wire dtm_pkg::dtm_req_type req_i,
    input wire logic cmd_err_o,
    input wire logic busy_o,
    input wire logic [OUT_W-1:0] rep_out_o,
    input wire logic rx_valid_i,
    input wire logic rx_sop_i,
    input wire logic [7:0] rx_data_i,
    input wire logic [15:0] exp_ident_i,
    input wire logic [31:0] data_left_i,
    input wire logic grant_valid_o,
    input wire logic grant_ready_i,
    input wire dtm_pkg::dtm_grant_type grant_o,
    input wire logic alert_o,
    input wire logic [7:0] alert_code_o
);
    logic off_q;
    logic [3:0] idx_q;
    logic [119:0] sh_q;
    wire [127:0] m = {sh_q, rx_data_i};
    wire last = rx_valid_i && !rx_sop_i && idx_q == 4'hf;
    wire hdr_ok = m[127:120] == 8'h21 && m[95:64] == cmd_route_i;
    wire al_ok = m[34:32] == 3'h0 || m[63:32] >= data_left_i;
    wire req_take = req_go_i && !busy_o && !rep_go_i;
    // Rebuilds the received message, so checks fire on its final byte
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            off_q <= 1'b0;
            idx_q <= 4'h0;
            sh_q <= 120'h0;
        end else begin
            off_q <= off_q | offer_valid_i;
            if (rx_valid_i) begin
                idx_q <= rx_sop_i ? 4'h1 : idx_q + 4'h1;
                sh_q <= {sh_q[111:0], rx_data_i};
            end
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_reply_needs_offer: assert property (
        rep_go_i && !busy_o && !off_q |=> cmd_err_o)
        else $error("reply taken without offer");
    a_reply_counted: assert property (
        rep_go_i && !busy_o && off_q && !rep_done_i && (rep_count_i[2:0] == 3'h0 || rep_last_i)
        |=> rep_out_o == $past(rep_out_o) + 1'b1)
        else $error("sent reply not counted");
    a_code_alert: assert property (
        last && m[127:120] != 8'h21 |=> alert_o && alert_code_o == 8'h03)
        else $error("unexpected message not alerted");
    a_route_alert: assert property (
        last && m[127:120] == 8'h21 && m[95:64] != cmd_route_i |=> alert_o && alert_code_o == 8'h01)
        else $error("bad route not alerted");
    a_align_alert: assert property (
        last && hdr_ok && !al_ok |=> alert_o && alert_code_o == 8'h02)
        else $error("odd count not alerted");
    a_ident_quiet: assert property (
        last && hdr_ok && al_ok && m[15:0] != exp_ident_i |=> !alert_o)
        else $error("bad identifier alerted");
    a_req_offset: assert property (
        req_take && req_i.offset[2:0] != 3'h0 |=> cmd_err_o)
        else $error("odd offset taken");
    a_req_limit: assert property (
        req_take && 33'(req_i.offset) + 33'(req_i.count) > 33'(xfer_len_i) |=> cmd_err_o)
        else $error("request past length taken");
    a_grant_hold: assert property (
        grant_valid_o && !grant_ready_i |=> grant_valid_o && $stable(grant_o))
        else $error("grant dropped or changed");
endmodule

bind dtm_handler dtm_chk #(.OUT_W(OUT_W)) i_chk (.sys_clk_i, .rst_b_i, .cmd_route_i, .xfer_len_i,
    .offer_valid_i, .rep_go_i, .rep_count_i, .rep_last_i, .rep_done_i, .req_go_i, .req_i, .cmd_err_o,
    .busy_o, .rep_out_o, .rx_valid_i, .rx_sop_i, .rx_data_i, .exp_ident_i, .data_left_i, .grant_valid_o,
    .grant_ready_i, .grant_o, .alert_o, .alert_code_o);

// ==== dv/dtm_peer.sv ====
// Far peer node: takes sent bytes, sends messages back.
// Assumes the handler's clock and byte stream.
`timescale 1ns/10ps
module dtm_peer (
    input wire logic sys_clk_i,
    input wire logic stall_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic rx_sop_o,
    output logic [7:0] rx_data_o
);
    logic [7:0] got[$];
    initial begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_sop_o = 1'b0;
        rx_data_o = 8'h00;
    end
    // Stalls on command so the buffer fills
    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o)
            got.push_back(tx_data_i);
        tx_ready_o <= !stall_i;
    end
    task automatic send(input logic [127:0] m);
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk_i);
            rx_valid_o <= 1'b1;
            rx_sop_o <= (i == 0);
            rx_data_o <= m[127-8*i -: 8];
        end
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b0;
        rx_sop_o <= 1'b0;
        // Idle bus must not look like data
        rx_data_o <= ~m[7:0];
    endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the message handler.
// Assumes core files and the peer model compile first.
`timescale 1ns/10ps
module testbench;
    logic sys_clk_i, rst_b_i, rep_last_i, rx_valid_i, rx_sop_i, grant_ready_i, tx_ready_i, stall;
    logic cmd_err_o, busy_o, grant_valid_o, alert_o, tx_valid_o;
    logic [6:0] pl;
    wire offer_valid_i, rep_go_i, rep_done_i, req_go_i, req_frame_first_i, req_done_i, xmit_done_i;
    logic [3:0] rep_out_o, req_out_o;
    logic [7:0] rx_data_i, alert_code_o, tx_data_o, code_seen;
    logic [15:0] cmd_tag_i = 16'h5a3c, exp_ident_i = 16'h1234, rep_chan_i;
    logic [31:0] cmd_route_i = 32'h11223344, xfer_len_i = 32'h100, own_route_i = 32'h0a0b0c0d;
    logic [31:0] rep_count_i, data_left_i;
    dtm_pkg::dtm_offer_type offer_i;
    dtm_pkg::dtm_req_type req_i;
    dtm_pkg::dtm_grant_type grant_o;
    int failures = 0, total_checks = 0, cyc = 0, errs = 0, alerts = 0;
    assign {offer_valid_i, rep_go_i, rep_done_i, req_go_i, req_frame_first_i, req_done_i, xmit_done_i} = pl;
    dtm_handler #(.OUT_W(4), .FIFO_DEPTH(8)) i_dut (.sys_clk_i, .rst_b_i, .cmd_tag_i, .cmd_route_i, .xfer_len_i,
        .own_route_i, .offer_valid_i, .offer_i, .rep_go_i, .rep_chan_i, .rep_count_i, .rep_last_i, .rep_done_i,
        .req_go_i, .req_i, .req_frame_first_i, .req_done_i, .cmd_err_o, .busy_o, .rep_out_o, .req_out_o,
        .rx_valid_i, .rx_sop_i, .rx_data_i, .exp_ident_i, .data_left_i, .grant_valid_o, .grant_ready_i,
        .grant_o, .xmit_done_i, .alert_o, .alert_code_o, .tx_valid_o, .tx_ready_i, .tx_data_o);
    dtm_peer i_peer (.sys_clk_i, .stall_i(stall), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_sop_o(rx_sop_i), .rx_data_o(rx_data_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cmd_err_o === 1'b1)
            errs++;
        if (alert_o === 1'b1) begin
            alerts++;
            code_seen = alert_code_o;
        end
        if (cyc == 5000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            finish_test();
        end
    end
    task finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic c, input string s);
        total_checks++;
        if (c !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task pulse(input logic [6:0] p);
        @(posedge sys_clk_i) pl <= p;
        @(posedge sys_clk_i) pl <= 7'h0;
        #1;
    endtask
    task expect_bytes(input int n, input logic [127:0] m);
        int w;
        w = 0;
        while (i_peer.got.size() < n && w < 400) begin
            tick(1);
            w++;
        end
        for (int i = 0; i < n; i++)
            chk(i_peer.got[i] === m[127-8*i -: 8], "byte mismatch");
        i_peer.got.delete();
    endtask
    function automatic logic [127:0] mk(input logic [7:0] c, input logic [31:0] r, n, input logic [15:0] id);
        // Nonzero reserved byte must be ignored on reception
        return {c, 8'h7e, 16'ha5c3, r, n, 16'h0005, id};
    endfunction
    task t_reply();
        int e;
        e = errs;
        pulse(7'h20);
        tick(3);
        chk(errs == e + 1 && rep_out_o === 4'h0, "reply without offer");
        @(posedge sys_clk_i);
        offer_i <= '{16'ha5c3, 16'h1234, 32'h40};
        rep_chan_i <= 16'h0102;
        rep_count_i <= 32'hc;
        stall <= 1'b1;
        pulse(7'h40);
        pulse(7'h20);
        tick(3);
        chk(errs == e + 2, "odd reply count taken");
        @(posedge sys_clk_i) rep_last_i <= 1'b1;
        pulse(7'h20);
        tick(24);
        chk(busy_o === 1'b1 && i_peer.got.size() == 0 && rep_out_o === 4'h1, "stalled reply");
        @(posedge sys_clk_i) stall <= 1'b0;
        expect_bytes(16, {8'h21, 8'h00, 16'ha5c3, 32'h0a0b0c0d, 32'hc, 16'h0102, 16'h1234});
        pulse(7'h10);
        tick(2);
        chk(rep_out_o === 4'h0 && tx_valid_o === 1'b0, "reply not retired");
    endtask
    task t_request();
        logic [63:0] bad [3];
        int e;
        bad = '{{32'h4, 32'h10}, {32'hf8, 32'h10}, {32'h0, 32'hc}};
        e = errs;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk_i) req_i <= {bad[i], 16'h0007};
            pulse(7'h08);
            tick(3);
            chk(errs == e + i + 1 && req_out_o === 4'h0, "bad request taken");
        end
        @(posedge sys_clk_i) req_i <= '{32'h8, 32'h10, 16'h0007};
        for (int i = 0; i < 3; i++) begin
            pulse(7'h08);
            if (i != 1) begin
                expect_bytes(14, {8'h22, 8'h00, 16'h5a3c, 32'h8, 32'h10, 16'h0007, 16'h0});
            end else begin
                tick(3);
                chk(errs == e + 4, "request not paced");
                pulse(7'h04);
            end
        end
        chk(req_out_o === 4'h2, "requests not counted");
        pulse(7'h02);
        pulse(7'h02);
        tick(2);
        chk(req_out_o === 4'h0, "requests not retired");
    endtask
    task t_receive();
        logic [127:0] msg [3];
        logic [7:0] want [3];
        int a;
        msg = '{mk(8'h22, 32'h11223344, 32'h10, 16'h1234), mk(8'h21, 32'h99, 32'h10, 16'h1234),
            mk(8'h21, 32'h11223344, 32'hc, 16'h1234)};
        want = '{8'h03, 8'h01, 8'h02};
        for (int i = 0; i < 3; i++) begin
            a = alerts;
            i_peer.send(msg[i]);
            tick(3);
            chk(alerts == a + 1 && code_seen === want[i] && grant_valid_o === 1'b0, "alert");
        end
        i_peer.send(mk(8'h21, 32'h11223344, 32'h10, 16'h4321));
        expect_bytes(4, {8'h03, 8'hff, 16'ha5c3, 96'h0});
        chk(alerts == a + 1, "identifier alerted");
        @(posedge sys_clk_i) data_left_i <= 32'hc;
        i_peer.send(msg[2]);
        tick(3);
        chk(grant_valid_o === 1'b1 && grant_o === dtm_pkg::dtm_grant_type'{16'h5, 32'h11223344, 32'hc},
            "grant");
        i_peer.send(mk(8'h21, 32'h11223344, 32'h10, 16'h1234));
        tick(3);
        chk(code_seen === 8'h04 && grant_o.count === 32'hc, "full slot");
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk_i) grant_ready_i <= 1'b1;
            @(posedge sys_clk_i) grant_ready_i <= 1'b0;
            if (i == 0)
                i_peer.send(mk(8'h21, 32'h11223344, 32'h10, 16'h1234));
            tick(3);
            chk(grant_valid_o === 1'b0, "grant overlaps channel");
            pulse(7'h01);
            tick(2);
            chk(grant_valid_o === (i == 0), "grant after done");
        end
    endtask
    initial begin
        rst_b_i = 1'b0;
        pl = 7'h0;
        stall = 1'b0;
        rep_last_i = 1'b0;
        grant_ready_i = 1'b0;
        rep_chan_i = 16'h0;
        rep_count_i = 32'h0;
        data_left_i = 32'h100;
        offer_i = 64'h0;
        req_i = 80'h0;
        tick(10);
        @(posedge sys_clk_i) rst_b_i <= 1'b1;
        tick(1);
        chk(busy_o === 1'b0 && alert_o === 1'b0 && rep_out_o === 4'h0 && tx_valid_o === 1'b0, "reset");
        t_reply();
        t_request();
        t_receive();
        finish_test();
    end
endmodule
